// ### core/ncm_map.svh
`ifndef NCM_MAP_SVH
`define NCM_MAP_SVH
// register indices; byte address is four times the index
`define NCM_IDX_CD_GAIN_A    6'h0E
`define NCM_IDX_CD_GAIN_B    6'h0F
`define NCM_IDX_CD_QMC_PHASE 6'h11
`define NCM_IDX_AB_OFFSET    6'h12
`define NCM_IDX_CD_OFFSET    6'h13
`define NCM_IDX_AB_INC_LO    6'h14
`define NCM_IDX_AB_INC_HI    6'h15
`define NCM_IDX_CD_INC_LO    6'h16
`define NCM_IDX_CD_INC_HI    6'h17
`define NCM_IDX_CORR_SYNC_EN 6'h1E
`define NCM_IDX_MIX_SYNC_EN  6'h1F
`define NCM_RST_CD_GAIN      16'h0400
`define NCM_RST_ZERO         16'h0000
`define NCM_GAIN_MSB         10
`define NCM_DELAY_MSB        13
`define NCM_DELAY_LSB        12
`define NCM_PHASE_MSB        11
`define NCM_SYNC_EN_BIT      0
`define NCM_GAIN_FRAC        10
`define NCM_PHASE_FRAC       12
`define NCM_FIFO_DEPTH       8
`define NCM_FIFO_WIDTH       32
`endif

// ### core/ncm_pkg.sv
`include "ncm_map.svh"
package ncm_pkg;
	typedef struct packed {
		logic [15:0] c;
		logic [15:0] d;
	} ncm_pair_s;

	typedef struct packed {
		logic [15:0] cd_gain_delay_reg_a;
		logic [15:0] cd_gain_delay_reg_b;
		logic [15:0] cd_qmc_phase;
		logic [15:0] ab_nco_phase_offset;
		logic [15:0] cd_nco_phase_offset;
		logic [15:0] ab_nco_increment_low;
		logic [15:0] ab_nco_increment_high;
		logic [15:0] cd_nco_increment_low;
		logic [15:0] cd_nco_increment_high;
		logic [15:0] correction_autosync_enable_reg;
		logic [15:0] mixer_autosync_enable_reg;
	} ncm_regs_s;

	typedef struct packed {
		logic [10:0] gain_c;
		logic [10:0] gain_d;
		logic [1:0]  delay_cd;
		logic [11:0] cd_pair_phase_correction;
	} ncm_qmc_s;

	typedef struct packed {
		logic [15:0] lookup_phase_offset;
		logic [31:0] frequency_increment;
	} ncm_nco_s;

	typedef struct packed {
		ncm_regs_s   regs;
		ncm_qmc_s    qmc;
		ncm_nco_s    ab_nco;
		ncm_nco_s    cd_nco;
		logic [31:0] ab_acc;
		logic [31:0] cd_acc;
		logic [15:0] ab_addr;
		logic [15:0] cd_addr;
		ncm_pair_s   out_pair;
		logic        out_valid;
		logic [31:0] prdata;
	} ncm_state_s;
endpackage

// ### core/ncm_mixer_qmc.sv
`timescale 1ns/1ns
`default_nettype none
//
// Overview of operation
// - cd phase word is 12-bit two's complement, -0.5 to 0.49975, reset zero
// - cd correction adds phase word times d sample into c sample
// - cd phase write with sync enabled loads cd gain, delay, phase together
// - with sync enabled, writes to cd gain/delay registers alone leave active correction unchanged
// - lookup address is phase offset plus upper 16 accumulator bits, per pair
// - ab offset write with sync enabled loads ab offset and ab increment
// - with sync enabled, ab increment writes leave running mixer unchanged until the sync
// - cd offset write with sync enabled loads cd offset and cd increment
// - with sync enabled, cd increment writes leave running mixer unchanged until the sync
// - ab increment is signed 32-bit, low half at index 0x14
// - increment lsb is fs over two to the 32nd, high half next register
//
`include "ncm_map.svh"

module ncm_fifo #(
	parameter int W = 32,
	parameter int D = 8
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW:0]         wp;
		logic [AW:0]         rp;
	} ncm_fifo_st_s;

	ncm_fifo_st_s s_q;
	ncm_fifo_st_s s_d;
	logic         full;
	logic         empty;

	assign empty = (s_q.wp == s_q.rp);
	assign full = (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]) && (s_q.wp[AW] != s_q.rp[AW]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = s_q.mem[s_q.rp[AW-1:0]];

	always_comb
	begin
		s_d = s_q;
		if (in_valid && !full)
		begin
			s_d.mem[s_q.wp[AW-1:0]] = in_data;
			s_d.wp = s_q.wp + 1'b1;
		end
		if (out_ready && !empty)
			s_d.rp = s_q.rp + 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end
endmodule // ncm_fifo

module ncm_mixer_qmc (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [11:0]      paddr,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [31:0]      pwdata,
	input  wire logic [3:0]       pstrb,
	output logic [31:0]           prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire ncm_pkg::ncm_pair_s in_pair,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output ncm_pkg::ncm_pair_s    out_pair,
	output logic [15:0]           ab_lut_addr,
	output logic [15:0]           cd_lut_addr,
	output logic [1:0]            cd_out_delay
);
	ncm_pkg::ncm_state_s s_q;
	ncm_pkg::ncm_state_s s_d;
	logic               f_valid;
	logic               f_ready;
	logic [31:0]        f_data;
	ncm_pkg::ncm_pair_s f_pair;
	logic               mapped;
	logic               wr;
	logic [5:0]         idx;
	logic [31:0]        nco_acc [2];
	logic [31:0]        nco_inc [2];
	logic [15:0]        nco_off [2];
	logic [31:0]        nco_acc_nxt [2];
	logic [15:0]        nco_addr_nxt [2];

	function automatic logic map_ok(input logic [11:0] a);
		logic [5:0] i;
		i = a[7:2];
		map_ok = (a[1:0] == 2'h0) && (a[11:8] == 4'h0) &&
			((i == `NCM_IDX_CD_GAIN_A) || (i == `NCM_IDX_CD_GAIN_B) ||
			((i >= `NCM_IDX_CD_QMC_PHASE) && (i <= `NCM_IDX_CD_INC_HI)) ||
			(i == `NCM_IDX_CORR_SYNC_EN) || (i == `NCM_IDX_MIX_SYNC_EN));
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
		merge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
	endfunction

	function automatic logic [15:0] sat16(input logic signed [31:0] v);
		if (v > 32'sh00007FFF)
			sat16 = 16'h7FFF;
		else if (v < -32'sh00008000)
			sat16 = 16'h8000;
		else
			sat16 = v[15:0];
	endfunction

	// staged register as seen on the bus, zero for holes
	function automatic logic [15:0] reg_value(input ncm_pkg::ncm_regs_s rg, input logic [5:0] i);
		case (i)
			`NCM_IDX_CD_GAIN_A:    reg_value = rg.cd_gain_delay_reg_a;
			`NCM_IDX_CD_GAIN_B:    reg_value = rg.cd_gain_delay_reg_b;
			`NCM_IDX_CD_QMC_PHASE: reg_value = rg.cd_qmc_phase;
			`NCM_IDX_AB_OFFSET:    reg_value = rg.ab_nco_phase_offset;
			`NCM_IDX_CD_OFFSET:    reg_value = rg.cd_nco_phase_offset;
			`NCM_IDX_AB_INC_LO:    reg_value = rg.ab_nco_increment_low;
			`NCM_IDX_AB_INC_HI:    reg_value = rg.ab_nco_increment_high;
			`NCM_IDX_CD_INC_LO:    reg_value = rg.cd_nco_increment_low;
			`NCM_IDX_CD_INC_HI:    reg_value = rg.cd_nco_increment_high;
			`NCM_IDX_CORR_SYNC_EN: reg_value = rg.correction_autosync_enable_reg;
			`NCM_IDX_MIX_SYNC_EN:  reg_value = rg.mixer_autosync_enable_reg;
			default:               reg_value = 16'h0000;
		endcase
	endfunction

	ncm_fifo #(
		.W (`NCM_FIFO_WIDTH),
		.D (`NCM_FIFO_DEPTH)
	) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (in_valid),
		.in_ready  (in_ready),
		.in_data   (in_pair),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data)
	);

	assign f_pair = f_data;
	assign f_ready = !s_q.out_valid || out_ready;
	assign mapped = map_ok(paddr);
	assign idx = paddr[7:2];
	assign wr = psel && penable && pwrite && mapped;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = s_q.prdata;
	assign out_valid = s_q.out_valid;
	assign out_pair = s_q.out_pair;
	assign ab_lut_addr = s_q.ab_addr;
	assign cd_lut_addr = s_q.cd_addr;
	assign cd_out_delay = s_q.qmc.delay_cd;
	assign nco_acc = '{s_q.ab_acc, s_q.cd_acc};
	assign nco_inc = '{s_q.ab_nco.frequency_increment, s_q.cd_nco.frequency_increment};
	assign nco_off = '{s_q.ab_nco.lookup_phase_offset, s_q.cd_nco.lookup_phase_offset};

	// index 0 is the ab pair, 1 the cd pair; sums wrap at their width
	for (genvar g = 0; g < 2; g++)
	begin : g_nco
		assign nco_acc_nxt[g] = nco_acc[g] + nco_inc[g];
		assign nco_addr_nxt[g] = nco_acc[g][31:16] + nco_off[g];
	end

	always_comb
	begin
		logic               corr_sync;
		logic               ab_sync;
		logic               cd_sync;
		logic signed [31:0] cg;
		logic signed [31:0] dg;
		logic signed [31:0] pc;
		logic [15:0]        dsat;
		ncm_pkg::ncm_regs_s r;
		s_d = s_q;
		corr_sync = 1'b0;
		ab_sync = 1'b0;
		cd_sync = 1'b0;
		cg = '0;
		dg = '0;
		pc = '0;
		dsat = '0;
		r = s_q.regs;
		if (wr)
		begin
			case (idx)
				`NCM_IDX_CD_GAIN_A:
					r.cd_gain_delay_reg_a = merge(r.cd_gain_delay_reg_a, pwdata, pstrb);
				`NCM_IDX_CD_GAIN_B:
					r.cd_gain_delay_reg_b = merge(r.cd_gain_delay_reg_b, pwdata, pstrb);
				`NCM_IDX_CD_QMC_PHASE:
				begin
					r.cd_qmc_phase = merge(r.cd_qmc_phase, pwdata, pstrb) & 16'h0FFF;
					corr_sync = 1'b1;
				end
				`NCM_IDX_AB_OFFSET:
				begin
					r.ab_nco_phase_offset = merge(r.ab_nco_phase_offset, pwdata, pstrb);
					ab_sync = 1'b1;
				end
				`NCM_IDX_CD_OFFSET:
				begin
					r.cd_nco_phase_offset = merge(r.cd_nco_phase_offset, pwdata, pstrb);
					cd_sync = 1'b1;
				end
				`NCM_IDX_AB_INC_LO:
					r.ab_nco_increment_low = merge(r.ab_nco_increment_low, pwdata, pstrb);
				`NCM_IDX_AB_INC_HI:
					r.ab_nco_increment_high = merge(r.ab_nco_increment_high, pwdata, pstrb);
				`NCM_IDX_CD_INC_LO:
					r.cd_nco_increment_low = merge(r.cd_nco_increment_low, pwdata, pstrb);
				`NCM_IDX_CD_INC_HI:
					r.cd_nco_increment_high = merge(r.cd_nco_increment_high, pwdata, pstrb);
				`NCM_IDX_CORR_SYNC_EN:
					r.correction_autosync_enable_reg = merge(r.correction_autosync_enable_reg, pwdata, pstrb) & 16'h0001;
				`NCM_IDX_MIX_SYNC_EN:
					r.mixer_autosync_enable_reg = merge(r.mixer_autosync_enable_reg, pwdata, pstrb) & 16'h0001;
				default:
					r = s_q.regs;
			endcase
		end
		s_d.regs = r;
		// sync disabled: working copy tracks staged values directly
		if (!r.correction_autosync_enable_reg[`NCM_SYNC_EN_BIT])
			corr_sync = 1'b1;
		if (!r.mixer_autosync_enable_reg[`NCM_SYNC_EN_BIT])
		begin
			ab_sync = 1'b1;
			cd_sync = 1'b1;
		end
		if (corr_sync)
		begin
			s_d.qmc.gain_c = r.cd_gain_delay_reg_a[`NCM_GAIN_MSB:0];
			s_d.qmc.gain_d = r.cd_gain_delay_reg_b[`NCM_GAIN_MSB:0];
			s_d.qmc.delay_cd = r.cd_gain_delay_reg_b[`NCM_DELAY_MSB:`NCM_DELAY_LSB];
			s_d.qmc.cd_pair_phase_correction = r.cd_qmc_phase[`NCM_PHASE_MSB:0];
		end
		if (ab_sync)
		begin
			s_d.ab_nco.lookup_phase_offset = r.ab_nco_phase_offset;
			s_d.ab_nco.frequency_increment = {r.ab_nco_increment_high, r.ab_nco_increment_low};
		end
		if (cd_sync)
		begin
			s_d.cd_nco.lookup_phase_offset = r.cd_nco_phase_offset;
			s_d.cd_nco.frequency_increment = {r.cd_nco_increment_high, r.cd_nco_increment_low};
		end
		s_d.ab_acc = nco_acc_nxt[0];
		s_d.cd_acc = nco_acc_nxt[1];
		s_d.ab_addr = nco_addr_nxt[0];
		s_d.cd_addr = nco_addr_nxt[1];
		if (f_ready)
			s_d.out_valid = f_valid;
		if (f_ready && f_valid)
		begin
			cg = ($signed(f_pair.c) * $signed({1'b0, s_q.qmc.gain_c})) >>> `NCM_GAIN_FRAC;
			dg = ($signed(f_pair.d) * $signed({1'b0, s_q.qmc.gain_d})) >>> `NCM_GAIN_FRAC;
			dsat = sat16(dg);
			// phase word / 4096 spans -0.5 .. 0.49975
			pc = ($signed(dsat) * $signed(s_q.qmc.cd_pair_phase_correction)) >>> `NCM_PHASE_FRAC;
			s_d.out_pair.c = sat16(cg + pc);
			s_d.out_pair.d = dsat;
		end
		if (psel && !penable)
		begin
			s_d.prdata = {16'h0000, reg_value(s_q.regs, idx)};
			if (!mapped)
				s_d.prdata = 32'h00000000;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q <= '0;
			s_q.regs.cd_gain_delay_reg_a <= `NCM_RST_CD_GAIN;
			s_q.regs.cd_gain_delay_reg_b <= `NCM_RST_CD_GAIN;
			s_q.regs.cd_qmc_phase <= `NCM_RST_ZERO;
			s_q.qmc.gain_c <= 11'(`NCM_RST_CD_GAIN);
			s_q.qmc.gain_d <= 11'(`NCM_RST_CD_GAIN);
		end
		else
			s_q <= s_d;
	end
endmodule // ncm_mixer_qmc
`default_nettype wire

// ### tb/ncm_mixer_qmc_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module ncm_mixer_qmc_checker (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic [11:0]        paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        prdata,
	input  wire logic               pready,
	input  wire logic               pslverr,
	input  wire logic               in_valid,
	input  wire logic               in_ready,
	input  wire logic               out_valid,
	input  wire logic               out_ready,
	input  wire ncm_pkg::ncm_pair_s out_pair
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire logic acs = psel && penable;
	AST_PREADY: assert property (acs |-> pready)
		else $error("no ready in access phase");
	AST_ERR_ACCESS: assert property (pslverr |-> acs)
		else $error("error outside access phase");
	AST_BAD_ADDR: assert property (acs && (paddr[1:0] != 2'h0 || paddr[11:8] != 4'h0) |-> pslverr)
		else $error("bad address not refused");
	AST_RD_UPPER: assert property (acs && !pwrite |-> prdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	AST_PHASE_RD: assert property (acs && !pwrite && paddr == 12'h044 |-> prdata[15:12] == 4'h0)
		else $error("phase word wider than 12 bits");
	AST_RD_HOLD: assert property (!psel |=> $stable(prdata))
		else $error("read data moved while idle");
	AST_OUT_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_pair))
		else $error("output dropped before accept");
	AST_OUT_LAT: assert property ($rose(out_valid) |-> $past(in_valid && in_ready, 2))
		else $error("output without push two edges before");
	COV_SYNC: cover property (acs && pwrite && paddr == 12'h044);
	COV_XFER: cover property (out_valid && out_ready);
	COV_FULL: cover property (in_valid && !in_ready);
	COV_ERR: cover property (pslverr);
endmodule // ncm_mixer_qmc_checker

bind ncm_mixer_qmc ncm_mixer_qmc_checker u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
	.prdata, .pready, .pslverr, .in_valid, .in_ready, .out_valid, .out_ready, .out_pair);
`default_nettype wire

// ### tb/ncm_mixer_qmc_test.sv
`timescale 1ns/1ns
`default_nettype none
module ncm_mixer_qmc_test;
	logic               pclk = 1'b0;
	logic               presetn = 1'b0;
	logic [11:0]        paddr = 12'h000;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite = 1'b0;
	logic [31:0]        pwdata = 32'h0;
	logic [3:0]         pstrb = 4'hF;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic               in_valid = 1'b0;
	logic               in_ready;
	ncm_pkg::ncm_pair_s in_pair = 32'h0;
	logic               out_valid;
	logic               out_ready = 1'b1;
	ncm_pkg::ncm_pair_s out_pair;
	logic [15:0]        ab_lut_addr;
	logic [15:0]        cd_lut_addr;
	logic [1:0]         cd_out_delay;
	int                 failures = 0;
	int                 n_checks = 0;
	int                 cycles = 0;
	logic [31:0]        rd;
	logic               er;

	ncm_mixer_qmc dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .in_valid, .in_ready, .in_pair, .out_valid, .out_ready, .out_pair,
		.ab_lut_addr, .cd_lut_addr, .cd_out_delay);

	always #5 pclk = ~pclk;

	task end_sim;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			end_sim();
		end
	end

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	// one apb transfer, entered just after a rising edge; one idle edge follows
	task apb(input logic [11:0] a, input logic w, input logic [15:0] d);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	function automatic logic [15:0] lut(input logic cd);
		return cd ? cd_lut_addr : ab_lut_addr;
	endfunction

	task xfer(input logic [15:0] c, input logic [15:0] d);
		in_valid <= 1'b1;
		in_pair <= {c, d};
		@(posedge pclk);
		in_valid <= 1'b0;
		for (int i = 0; i < 20 && out_valid !== 1'b1; i++)
			@(posedge pclk);
	endtask

	task t_regs;
		logic [11:0] a[6];
		a = '{12'h038, 12'h03C, 12'h044, 12'h048, 12'h04C, 12'h050};
		for (int i = 0; i < 6; i++)
		begin
			apb(a[i], 1'b0, 16'h0000);
			chk("reset value", (i < 2) ? 32'h0400 : 32'h0, rd);
		end
		apb(12'h040, 1'b0, 16'h0000);
		chk("unmapped error", 32'h1, {31'h0, er});
		apb(12'h044, 1'b1, 16'hFFFF);
		apb(12'h044, 1'b0, 16'h0000);
		chk("phase width", 32'h0FFF, rd);
		pstrb <= 4'h2;
		apb(12'h044, 1'b1, 16'h0000);
		pstrb <= 4'hF;
		apb(12'h044, 1'b0, 16'h0000);
		chk("byte strobe", 32'h00FF, rd);
		apb(12'h044, 1'b1, 16'h0000);
	endtask

	task t_fifo;
		int n;
		int m;
		n = 0;
		m = 0;
		out_ready <= 1'b0;
		in_valid <= 1'b1;
		repeat (12)
		begin
			in_pair <= {n[15:0], 16'h0000};
			@(posedge pclk);
			if (in_ready === 1'b1)
				n++;
		end
		in_valid <= 1'b0;
		chk("words taken", 32'd9, n);
		out_ready <= 1'b1;
		repeat (16)
		begin
			@(posedge pclk);
			if (out_valid === 1'b1)
			begin
				chk("fifo order", m, out_pair.c);
				m++;
			end
		end
		chk("words drained", 32'd9, m);
	endtask

	task t_qmc;
		apb(12'h078, 1'b1, 16'h0001);
		xfer(16'h0100, 16'h0400);
		chk("unity pair", 32'h0100_0400, out_pair);
		apb(12'h038, 1'b1, 16'h0200);
		apb(12'h03C, 1'b1, 16'h1400);
		xfer(16'h0100, 16'h0400);
		chk("staged pair", 32'h0100_0400, out_pair);
		chk("staged delay", 32'h0, cd_out_delay);
		apb(12'h044, 1'b1, 16'h0800);
		xfer(16'h0100, 16'h0400);
		chk("synced pair", 32'hFE80_0400, out_pair);
		chk("synced delay", 32'h1, cd_out_delay);
	endtask

	task t_nco(input logic cd);
		logic [11:0] b;
		logic [11:0] h;
		logic [15:0] l;
		logic [11:0] lo;
		b = cd ? 12'h04C : 12'h048;
		lo = cd ? 12'h058 : 12'h050;
		h = cd ? 12'h05C : 12'h054;
		apb(h, 1'b1, 16'h0001);
		repeat (3) @(posedge pclk);
		chk("staged increment", 32'h0, lut(cd));
		apb(b, 1'b1, 16'h0000);
		repeat (3) @(posedge pclk);
		l = lut(cd);
		@(posedge pclk);
		chk("up step", 16'(l + 16'h0001), lut(cd));
		apb(h, 1'b1, 16'hFFFF);
		apb(b, 1'b1, 16'h0000);
		repeat (3) @(posedge pclk);
		l = lut(cd);
		@(posedge pclk);
		chk("down step", 16'(l - 16'h0001), lut(cd));
		apb(h, 1'b1, 16'h0000);
		apb(b, 1'b1, 16'h0000);
		repeat (3) @(posedge pclk);
		l = lut(cd);
		apb(b, 1'b1, 16'h1234);
		repeat (3) @(posedge pclk);
		chk("offset added", 16'(l + 16'h1234), lut(cd));
		apb(lo, 1'b1, 16'h8000);
		apb(b, 1'b1, 16'h1234);
		repeat (3) @(posedge pclk);
		l = lut(cd);
		repeat (2) @(posedge pclk);
		chk("low half step", 16'(l + 16'h0001), lut(cd));
	endtask

	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_fifo();
		t_qmc();
		apb(12'h07C, 1'b1, 16'h0001);
		t_nco(1'b0);
		t_nco(1'b1);
		end_sim();
	end
endmodule // ncm_mixer_qmc_test
`default_nettype wire
